// file: core/dac_regs_pkg.sv
// Register map, reset values and field layout of the volume and power register slice
package dac_regs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_VOL_CH11 = 8'h16;
   localparam logic [7:0] ADDR_VOL_CH12 = 8'h17;
   localparam logic [7:0] ADDR_PAD_DRIVE = 8'h1c;
   localparam logic [7:0] ADDR_POWER_1_4 = 8'h1d;
   localparam logic [7:0] ADDR_POWER_5_8 = 8'h1e;
   localparam logic [7:0] RESET_VOL = 8'h00;
   localparam logic [7:0] RESET_PAD_DRIVE = 8'h02;
   localparam logic [7:0] RESET_POWER = 8'haa;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // Every reset power field is the best performance code
   localparam logic [7:0] RESET_BEST = 8'hff;
   localparam int PAD_DRIVE_BIT = 5;
   localparam int POWER_FIELD_W = 2;
   localparam int POWER_FIELDS = 4;
   // Attenuation in thousandths of a dB per code step
   localparam int VOL_STEP_MDB = 375;
   localparam int ATTEN_W = 17;
   localparam logic [7:0] VOL_CODE_ZERO = 8'h00;
   localparam logic [7:0] VOL_CODE_NEAR_MAX = 8'hfe;
   localparam logic [7:0] VOL_CODE_MAX = 8'hff;
   localparam int ATTEN_NEAR_MAX_MDB = 95250;
   localparam int ATTEN_MAX_MDB = 95625;
   typedef enum logic [1:0] {
      power_low = 2'h0,
      power_lowest = 2'h1,
      power_best = 2'h2,
      power_good = 2'h3
   } power_mode_t;
endpackage

// file: core/power_field_decode.sv
// Decoder of one two-bit channel power mode field into one-hot mode flags
`timescale 1ns/1ps
module power_field_decode
   import dac_regs_pkg::*;
(
   input wire logic [1:0] field_in,
   output logic low_power_out,
   output logic lowest_power_out,
   output logic best_perf_out,
   output logic good_perf_out
);
   assign low_power_out = (field_in == power_low);
   assign lowest_power_out = (field_in == power_lowest);
   assign best_perf_out = (field_in == power_best);
   assign good_perf_out = (field_in == power_good);
endmodule

// file: core/dac_volume_power_regs.sv
// Volume, pad drive and power mode registers behind the serial control port
`timescale 1ns/1ps
module dac_volume_power_regs
   import dac_regs_pkg::*;
(
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   output logic [DATA_W-1:0] rdata_out,
   output logic rvalid_out,
   output logic [DATA_W-1:0] volume_channel_eleven_out,
   output logic [DATA_W-1:0] volume_channel_twelve_out,
   output logic [ATTEN_W-1:0] atten_mdb_ch11_out,
   output logic [ATTEN_W-1:0] atten_mdb_ch12_out,
   output logic pad_drive_select_out,
   output logic [DATA_W-1:0] common_mode_pad_drive_out,
   output logic [7:0] power_mode_ch1_4_out,
   output logic [7:0] power_mode_ch5_8_out,
   output logic [7:0] best_perf_ch1_8_out
);
   logic [DATA_W-1:0] vol11_reg;
   logic [DATA_W-1:0] vol12_reg;
   logic [DATA_W-1:0] pad_reg;
   logic [DATA_W-1:0] pow14_reg;
   logic [DATA_W-1:0] pow58_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic rvalid_reg;
   logic [ATTEN_W-1:0] att11_reg;
   logic [ATTEN_W-1:0] att12_reg;
   logic [7:0] best_reg;

   wire sel_vol11 = (addr_in == ADDR_VOL_CH11);
   wire sel_vol12 = (addr_in == ADDR_VOL_CH12);
   wire sel_pad = (addr_in == ADDR_PAD_DRIVE);
   wire sel_pow14 = (addr_in == ADDR_POWER_1_4);
   wire sel_pow58 = (addr_in == ADDR_POWER_5_8);

   wire [DATA_W-1:0] rdata_next = sel_vol11 ? vol11_reg :
                                  sel_vol12 ? vol12_reg :
                                  sel_pad ? pad_reg :
                                  sel_pow14 ? pow14_reg :
                                  sel_pow58 ? pow58_reg : READ_UNMAPPED;

   // Attenuation in mdB is code times step; zero code gives 0 dB
   wire [ATTEN_W-1:0] att11_next = ATTEN_W'(vol11_reg) * ATTEN_W'(VOL_STEP_MDB);
   wire [ATTEN_W-1:0] att12_next = ATTEN_W'(vol12_reg) * ATTEN_W'(VOL_STEP_MDB);

   wire [15:0] power_all = {pow58_reg, pow14_reg};
   wire [7:0] best_next;

   genvar gi;
   generate
      for (gi = 0; gi < 2 * POWER_FIELDS; gi++) begin : g_dec
         power_field_decode u_dec (
            .field_in(power_all[gi*POWER_FIELD_W +: POWER_FIELD_W]),
            .low_power_out(),
            .lowest_power_out(),
            .best_perf_out(best_next[gi]),
            .good_perf_out()
         );
      end
   endgenerate

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         vol11_reg <= RESET_VOL;
         vol12_reg <= RESET_VOL;
         pad_reg <= RESET_PAD_DRIVE;
         pow14_reg <= RESET_POWER;
         pow58_reg <= RESET_POWER;
      end else if (wr_en_in) begin
         if (sel_vol11) vol11_reg <= wdata_in;
         if (sel_vol12) vol12_reg <= wdata_in;
         if (sel_pad) pad_reg <= wdata_in;
         if (sel_pow14) pow14_reg <= wdata_in;
         if (sel_pow58) pow58_reg <= wdata_in;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_reg <= READ_UNMAPPED;
         rvalid_reg <= 1'b0;
         att11_reg <= '0;
         att12_reg <= '0;
         best_reg <= RESET_BEST;
      end else begin
         rdata_reg <= rd_en_in ? rdata_next : rdata_reg;
         rvalid_reg <= rd_en_in;
         att11_reg <= att11_next;
         att12_reg <= att12_next;
         best_reg <= best_next;
      end
   end

   assign rdata_out = rdata_reg;
   assign rvalid_out = rvalid_reg;
   assign volume_channel_eleven_out = vol11_reg;
   assign volume_channel_twelve_out = vol12_reg;
   assign atten_mdb_ch11_out = att11_reg;
   assign atten_mdb_ch12_out = att12_reg;
   assign pad_drive_select_out = pad_reg[PAD_DRIVE_BIT];
   assign common_mode_pad_drive_out = pad_reg;
   assign power_mode_ch1_4_out = pow14_reg;
   assign power_mode_ch5_8_out = pow58_reg;
   assign best_perf_ch1_8_out = best_reg;

   // Writes land on the next edge; without a write each register holds
   a_vol_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
      wr_en_in && sel_vol11 |=> vol11_reg == $past(wdata_in))
      else $error("channel 11 volume write lost");
   a_vol11_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !(wr_en_in && sel_vol11) |=> $stable(vol11_reg))
      else $error("channel 11 volume changed without write");
   a_vol12_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
      wr_en_in && sel_vol12 |=> vol12_reg == $past(wdata_in))
      else $error("channel 12 volume write lost");
   a_vol12_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !(wr_en_in && sel_vol12) |=> $stable(vol12_reg))
      else $error("channel 12 volume changed without write");
   a_pad_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
      wr_en_in && sel_pad |=> pad_reg == $past(wdata_in))
      else $error("pad register write lost");
   a_pad_bit: assert property (@(posedge clock_in) disable iff (!resetn_in)
      wr_en_in && sel_pad |=> pad_drive_select_out == $past(wdata_in[PAD_DRIVE_BIT]))
      else $error("pad drive bit not following write");
   a_pad_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !(wr_en_in && sel_pad) |=> $stable(pad_reg))
      else $error("pad register changed without write");
   a_pow14_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
      wr_en_in && sel_pow14 |=> pow14_reg == $past(wdata_in))
      else $error("power 1-4 write lost");
   a_pow_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !(wr_en_in && sel_pow14) |=> $stable(pow14_reg))
      else $error("power 1-4 changed without write");
   a_pow58_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
      wr_en_in && sel_pow58 |=> pow58_reg == $past(wdata_in))
      else $error("power 5-8 write lost");
   a_pow58_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !(wr_en_in && sel_pow58) |=> $stable(pow58_reg))
      else $error("power 5-8 changed without write");

   // Attenuation view trails the volume code by one edge
   a_atten_step: assert property (@(posedge clock_in) disable iff (!resetn_in)
      ##1 att11_reg == ATTEN_W'($past(vol11_reg)) * ATTEN_W'(VOL_STEP_MDB))
      else $error("attenuation not code times step");
   a_atten_step12: assert property (@(posedge clock_in) disable iff (!resetn_in)
      ##1 att12_reg == ATTEN_W'($past(vol12_reg)) * ATTEN_W'(VOL_STEP_MDB))
      else $error("channel 12 attenuation not code times step");
   a_atten_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $past(vol12_reg) == VOL_CODE_ZERO |-> att12_reg == '0)
      else $error("zero code not 0 dB");
   a_atten_zero11: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $past(vol11_reg) == VOL_CODE_ZERO |-> att11_reg == '0)
      else $error("channel 11 zero code not 0 dB");
   a_atten_max: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $past(vol12_reg) == VOL_CODE_MAX |-> att12_reg == ATTEN_W'(ATTEN_MAX_MDB))
      else $error("full code not 95.625 dB");
   a_atten_max11: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $past(vol11_reg) == VOL_CODE_MAX |-> att11_reg == ATTEN_W'(ATTEN_MAX_MDB))
      else $error("channel 11 full code not 95.625 dB");
   a_atten_near: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $past(vol11_reg) == VOL_CODE_NEAR_MAX |-> att11_reg == ATTEN_W'(ATTEN_NEAR_MAX_MDB))
      else $error("channel 11 code fe not 95.250 dB");
   a_atten_near12: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $past(vol12_reg) == VOL_CODE_NEAR_MAX |-> att12_reg == ATTEN_W'(ATTEN_NEAR_MAX_MDB))
      else $error("channel 12 code fe not 95.250 dB");

   // Best performance flags trail the power fields by one edge
   a_best_decode: assert property (@(posedge clock_in) disable iff (!resetn_in)
      ##1 best_reg[4] == ($past(pow58_reg[POWER_FIELD_W-1:0]) == power_best))
      else $error("channel 5 best performance decode wrong");
   generate
      for (gi = 0; gi < POWER_FIELDS; gi++) begin : g_best14_chk
         a_best_ch1_4: assert property (@(posedge clock_in) disable iff (!resetn_in)
            ##1 best_reg[gi] == ($past(pow14_reg[gi*POWER_FIELD_W +: POWER_FIELD_W]) == power_best))
            else $error("channel 1-4 best performance decode wrong");
      end
      for (gi = 0; gi < POWER_FIELDS; gi++) begin : g_best58_chk
         a_best_ch5_8: assert property (@(posedge clock_in) disable iff (!resetn_in)
            ##1 best_reg[gi + POWER_FIELDS] == ($past(pow58_reg[gi*POWER_FIELD_W +: POWER_FIELD_W]) == power_best))
            else $error("channel 5-8 best performance decode wrong");
      end
   endgenerate

   // Read data comes from the register at the strobe edge, then stands
   a_read_back: assert property (@(posedge clock_in) disable iff (!resetn_in)
      rd_en_in && sel_pow58 |=> rvalid_out && rdata_out == $past(pow58_reg))
      else $error("power 5-8 readback wrong");
   a_read_vol11: assert property (@(posedge clock_in) disable iff (!resetn_in)
      rd_en_in && sel_vol11 |=> rvalid_out && rdata_out == $past(vol11_reg))
      else $error("channel 11 volume readback wrong");
   a_read_vol12: assert property (@(posedge clock_in) disable iff (!resetn_in)
      rd_en_in && sel_vol12 |=> rvalid_out && rdata_out == $past(vol12_reg))
      else $error("channel 12 volume readback wrong");
   a_read_pad: assert property (@(posedge clock_in) disable iff (!resetn_in)
      rd_en_in && sel_pad |=> rvalid_out && rdata_out == $past(pad_reg))
      else $error("pad register readback wrong");
   a_read_pow14: assert property (@(posedge clock_in) disable iff (!resetn_in)
      rd_en_in && sel_pow14 |=> rvalid_out && rdata_out == $past(pow14_reg))
      else $error("power 1-4 readback wrong");
   a_rvalid_pulse: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !rd_en_in |=> !rvalid_out)
      else $error("read valid without read strobe");
   a_rdata_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !rd_en_in |=> $stable(rdata_out))
      else $error("read data changed without read strobe");
endmodule

// file: testbench/host_port_model.sv
// Host side model issuing single-cycle register strobes
`timescale 1ns/1ps
module host_port_model (
   input wire logic clock_in,
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out
);
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_in);
      wr_en_out = wr;
      rd_en_out = !wr;
      addr_out = a;
      wdata_out = d;
      @(negedge clock_in);
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      // Released lines show no stale value
      addr_out = ~a;
      wdata_out = ~d;
   endtask
endmodule

// file: testbench/dac_volume_power_regs_test.sv
// Self-checking bench for the volume, pad drive and power mode registers
`timescale 1ns/1ps
module dac_volume_power_regs_test;
   import dac_regs_pkg::*;
   logic clock_in = 1'b0;
   logic resetn_in = 1'b0;
   logic wr_en_in, rd_en_in, rvalid_out, pad_drive_select_out;
   logic [7:0] addr_in, wdata_in, rdata_out, vol11, vol12, pad_reg, pw14, pw58, best;
   logic [16:0] att11, att12;
   int error_cnt = 0;
   int checks = 0;
   int seed = 32'hc945;
   int model [logic [7:0]];
   logic [7:0] adrs [7] = '{8'h16, 8'h17, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h18};
   logic [7:0] a;
   always #2 clock_in = ~clock_in;
   host_port_model host (.clock_in, .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .addr_out(addr_in),
      .wdata_out(wdata_in));
   dac_volume_power_regs dut (.clock_in, .resetn_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in,
      .rdata_out, .rvalid_out, .volume_channel_eleven_out(vol11), .volume_channel_twelve_out(vol12),
      .atten_mdb_ch11_out(att11), .atten_mdb_ch12_out(att12), .pad_drive_select_out,
      .common_mode_pad_drive_out(pad_reg), .power_mode_ch1_4_out(pw14), .power_mode_ch5_8_out(pw58),
      .best_perf_ch1_8_out(best));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic load_reset;
      model[8'h16] = 'h00;
      model[8'h17] = 'h00;
      model[8'h1c] = 'h02;
      model[8'h1d] = 'haa;
      model[8'h1e] = 'haa;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      host.access(1'b1, adr, dat);
      if (model.exists(adr)) model[adr] = dat;
   endtask
   task automatic rd_chk(input logic [7:0] adr);
      host.access(1'b0, adr, 8'h00);
      check(rvalid_out, 1'b1);
      check(rdata_out, model.exists(adr) ? model[adr] : 0);
   endtask
   task automatic out_chk;
      logic [15:0] f;
      f = 16'((model[8'h1e] << 8) | model[8'h1d]);
      @(negedge clock_in);
      check(vol11, model[8'h16]);
      check(vol12, model[8'h17]);
      check(att11, model[8'h16] * 375);
      check(att12, model[8'h17] * 375);
      check(pad_drive_select_out, model[8'h1c] >> 5 & 1);
      check(pad_reg, model[8'h1c]);
      check(pw14, model[8'h1d]);
      check(pw58, model[8'h1e]);
      check(rvalid_out, 1'b0);
      for (int i = 0; i < 8; i++) begin
         check(best[i], (f >> 2 * i & 3) == 2);
      end
   endtask
   initial begin
      load_reset();
      repeat (2) @(negedge clock_in);
      resetn_in = 1'b1;
      foreach (model[k]) rd_chk(k);
      rd_chk(8'h1f);
      out_chk();
      $display("reset values test done");
      wr(8'h16, 8'hff);
      wr(8'h17, 8'hfe);
      wr(8'h1d, 8'he4);
      wr(8'h1e, 8'h1b);
      out_chk();
      wr(8'h16, 8'hfe);
      wr(8'h17, 8'hff);
      out_chk();
      check(att11, 95250);
      check(att12, 95625);
      for (int n = 0; n < 60; n++) begin
         a = adrs[$unsigned($random(seed)) % 7];
         wr(a, 8'($random(seed)));
         out_chk();
         rd_chk(a);
      end
      $display("random access test done");
      @(negedge clock_in);
      resetn_in = 1'b0;
      load_reset();
      @(negedge clock_in);
      resetn_in = 1'b1;
      foreach (model[k]) rd_chk(k);
      out_chk();
      $display("second reset test done");
      wrap_up();
   end
   initial begin
      #20000;
      error_cnt++;
      wrap_up();
   end
endmodule
